// ==== cofc_top.sv ====
// Summary of operation
// - Bits 22:20 choose filter clock source
// - Bit 19 set filters, clear bypasses
// - Bits 18:16 divide sample clock by 2**n
// - Divider follows currently selected source
// - Bit 15 enables channel, resets 0
// - Bits 31:23 read zero, ignore writes
// - Flags set on events regardless of mask
`timescale 1ns/10ps
module cofc_top
  import cofc_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  comp_raw,
  input  wire cofc_pkg::cofc_ticks_t ticks,
  output logic                       comp_enable,
  output logic                       comparator_output_state,
  output logic                       irq
);
  import cofc_pkg::*;

  logic [31:0] ctrl_ff;
  logic [EV_W-1:0] status_ff;
  logic [EV_W-1:0] mask_ff;
  logic        raw_s1_ff;
  logic        raw_s2_ff;
  logic        filt_ff;
  logic        out_prev_ff;
  logic [1:0]  same_ff;
  logic        ack_ff;
  logic        src_tick;
  logic        div_tick;
  logic        nxt_out;
  logic [31:0] wbe;
  logic        wr_go;
  logic        rd_go;
  logic [EV_W-1:0] ev;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_mask;

  // Byte enables widened to a bit mask
  assign wbe = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // Writes land at the edge after the wait cycle, ending the cycle with waitrequest low
  assign wr_go = avs_write && ack_ff;
  assign rd_go = avs_read && !ack_ff;

  // Write strobes, one per register
  always_comb
  begin
    wr_ctrl   = 1'b0;
    wr_status = 1'b0;
    wr_mask   = 1'b0;
    if (wr_go && avs_address == CTRL_ADDR)
    begin
      wr_ctrl = 1'b1;
    end
    else if (wr_go && avs_address == STATUS_ADDR)
    begin
      wr_status = 1'b1;
    end
    else if (wr_go && avs_address == MASK_ADDR)
    begin
      wr_mask = 1'b1;
    end
  end

  // One wait cycle, then the access completes
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ack_ff          <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      ack_ff          <= (avs_read || avs_write) && !ack_ff;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
    end
  end

  // Control register
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_ff <= CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl_ff <= (ctrl_ff & ~(wbe & CTRL_WMASK))
               | (avs_writedata & wbe & CTRL_WMASK);
    end
  end

  // Mask register
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      mask_ff <= '0;
    end
    else if (wr_mask && avs_byteenable[0])
    begin
      mask_ff <= avs_writedata[EV_W-1:0];
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      status_ff <= '0;
    end
    else if (wr_status && avs_byteenable[0])
    begin
      status_ff <= (status_ff & ~avs_writedata[EV_W-1:0]) | ev;
    end
    else
    begin
      status_ff <= status_ff | ev;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_ff & mask_ff);
    end
  end

  // Read data
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (rd_go)
    begin
      if (avs_address == CTRL_ADDR)
      begin
        avs_readdata <= (ctrl_ff & CTRL_WMASK)
                      | (32'(comparator_output_state) << OUT_BIT);
      end
      else if (avs_address == STATUS_ADDR)
      begin
        avs_readdata <= 32'(status_ff);
      end
      else if (avs_address == MASK_ADDR)
      begin
        avs_readdata <= 32'(mask_ff);
      end
      else
      begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // Source select
  always_comb
  begin
    case (cofc_src_t'(ctrl_ff[SEL_LSB +: 3]))
      SRC_SYS:  src_tick = 1'b1;
      SRC_PB:   src_tick = ticks.pb_tick;
      SRC_PWM:  src_tick = ticks.pwm_event;
      SRC_REF:  src_tick = ticks.ref_tick;
      SRC_TMR2: src_tick = ticks.tmr_match[0];
      SRC_TMR3: src_tick = ticks.tmr_match[1];
      SRC_TMR4: src_tick = ticks.tmr_match[2];
      default:  src_tick = ticks.tmr_match[3];
    endcase
  end

  cofc_divider u_div (
    .mclk     (mclk),
    .reset    (reset),
    .tick_in  (src_tick),
    .code     (ctrl_ff[DIV_LSB +: 3]),
    .tick_out (div_tick)
  );

  // Raw comparator synchroniser
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      raw_s1_ff <= 1'b0;
      raw_s2_ff <= 1'b0;
    end
    else
    begin
      raw_s1_ff <= comp_raw;
      raw_s2_ff <= raw_s1_ff;
    end
  end

  // Stability filter on divided samples
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      filt_ff <= 1'b0;
      same_ff <= 2'h0;
    end
    else if (div_tick)
    begin
      if (raw_s2_ff == filt_ff)
      begin
        same_ff <= 2'h0;
      end
      else if (same_ff == 2'(FILT_SAMPLES - 1))
      begin
        filt_ff <= raw_s2_ff;
        same_ff <= 2'h0;
      end
      else
      begin
        same_ff <= same_ff + 2'h1;
      end
    end
  end

  // Bypass or filtered level, forced low while off
  always_comb
  begin
    if (!ctrl_ff[ON_BIT])
    begin
      nxt_out = 1'b0;
    end
    else if (ctrl_ff[FEN_BIT])
    begin
      nxt_out = filt_ff;
    end
    else
    begin
      nxt_out = raw_s2_ff;
    end
  end

  // Output state pin
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      comparator_output_state <= 1'b0;
    end
    else
    begin
      comparator_output_state <= nxt_out;
    end
  end

  // Previous output for edge detection
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      out_prev_ff <= 1'b0;
    end
    else
    begin
      out_prev_ff <= comparator_output_state;
    end
  end

  // Enable pin to the analog front end
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      comp_enable <= 1'b0;
    end
    else
    begin
      comp_enable <= ctrl_ff[ON_BIT];
    end
  end

  // Edge events only while enabled
  always_comb
  begin
    if (ctrl_ff[ON_BIT])
    begin
      ev[EV_RISE] = ~out_prev_ff & comparator_output_state;
      ev[EV_FALL] = out_prev_ff & ~comparator_output_state;
    end
    else
    begin
      ev = '0;
    end
  end

endmodule

// ==== cofc_pkg.sv ====
package cofc_pkg;

  // Register byte addresses
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] MASK_ADDR   = 4'h8;

  // Control field positions
  localparam int SEL_LSB    = 20;
  localparam int FEN_BIT    = 19;
  localparam int DIV_LSB    = 16;
  localparam int ON_BIT     = 15;
  localparam int OUT_BIT    = 8;

  // Writable control bits: 22..16 and 15
  localparam logic [31:0] CTRL_WMASK = 32'h007F_8000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status bits
  localparam int EV_RISE = 0;
  localparam int EV_FALL = 1;
  localparam int EV_W    = 2;

  // Filter sample count
  localparam int FILT_SAMPLES = 3;

  // Clock source codes
  typedef enum logic [2:0] {
    SRC_SYS  = 3'h0,
    SRC_PB   = 3'h1,
    SRC_PWM  = 3'h2,
    SRC_REF  = 3'h3,
    SRC_TMR2 = 3'h4,
    SRC_TMR3 = 3'h5,
    SRC_TMR4 = 3'h6,
    SRC_TMR5 = 3'h7
  } cofc_src_t;

  // Source tick inputs, all one-cycle pulses on mclk
  typedef struct packed {
    logic       pb_tick;
    logic       pwm_event;
    logic       ref_tick;
    logic [3:0] tmr_match;
  } cofc_ticks_t;

  // Ratio 2**code minus one, as a terminal count
  function automatic logic [6:0] div_term(input logic [2:0] code);
    div_term = 7'((8'h01 << code) - 8'h01);
  endfunction

endpackage

// ==== cofc_divider.sv ====
`timescale 1ns/10ps
module cofc_divider
  import cofc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       tick_in,
  input  wire logic [2:0] code,
  output logic            tick_out
);
  import cofc_pkg::*;

  logic [6:0] count_ff;

  // Power-of-two prescale of the selected source
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      count_ff <= 7'h00;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= 1'b0;
      if (tick_in)
      begin
        if (count_ff >= div_term(code))
        begin
          count_ff <= 7'h00;
          tick_out <= 1'b1;
        end
        else
        begin
          count_ff <= count_ff + 7'h01;
        end
      end
    end
  end

endmodule

// ==== cofc_asserts.sv ====
`timescale 1ns/10ps
module cofc_asserts
  import cofc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        comp_enable,
  input wire logic        comparator_output_state,
  input wire logic        irq
);
  logic rd;
  logic wr;
  assign rd = avs_read & ~avs_waitrequest;
  assign wr = avs_write & ~avs_waitrequest;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wait_low_a: assert property (
    (avs_read | avs_write) & avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long ack");
  hi_zero_a: assert property (
    rd |-> avs_readdata[31:23] == 9'h000) else $error("upper bits set");
  unmap_zero_a: assert property (
    rd & (avs_address > 4'h8) |-> avs_readdata == '0) else $error("unmapped data");
  on_write_a: assert property (
    wr & avs_address == CTRL_ADDR & avs_byteenable[1] |->
    ##2 comp_enable == $past(avs_writedata[15], 2)) else $error("enable mismatch");
  off_out_a: assert property (
    !comp_enable & !$past(comp_enable) |-> !comparator_output_state) else $error("output when off");
  mask_off_a: assert property (
    wr & avs_address == MASK_ADDR & avs_byteenable[0] & avs_writedata[7:0] == 8'h00 |->
    ##2 !irq) else $error("irq while masked");
  rst_idle_a: assert property (disable iff (1'h0)
    reset |=> avs_waitrequest & !irq & !comp_enable) else $error("reset values");
  cover property (irq);
  cover property ($rose(comparator_output_state));
  cover property (rd & avs_address == CTRL_ADDR);
endmodule
bind cofc_top cofc_asserts i_cofc_asserts (.*);

// ==== cofc_top_tb.sv ====
`timescale 1ns/10ps
module cofc_top_tb;
  import cofc_pkg::*;
  logic        mclk = 1'h0;
  logic        reset = 1'h1;
  logic [3:0]  avs_address = '0;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = '0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        comp_raw = 1'h0;
  cofc_ticks_t ticks = '0;
  logic        comp_enable;
  logic        comparator_output_state;
  logic        irq;
  logic [31:0] q[$];
  logic [31:0] e;
  logic [6:0]  m;
  logic        v = 1'h0;
  int          failures = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #50 mclk = ~mclk;
  cofc_top i_cofc_top (.*);
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    n_tests++;
    if (s !== x)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic results;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Read pushes its expected data
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    if (!w)
      q.push_back(d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= w ? d : '0;
    @(posedge mclk);
    while (avs_waitrequest !== 1'h0)
      @(posedge mclk);
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic tk(input logic [6:0] k, input int n);
    repeat (n)
    begin
      ticks <= cofc_ticks_t'(k);
      @(posedge mclk);
      ticks <= '0;
      @(posedge mclk);
    end
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (avs_read && avs_waitrequest === 1'h0)
      chk("readdata", q.pop_front(), avs_readdata);
    if (cyc == 6000)
    begin
      failures++;
      results();
    end
  end
  initial
  begin
    void'($urandom(32'h1CF8));
    repeat (8) @(posedge mclk);
    reset <= 1'h0;
    bus(1'h0, CTRL_ADDR, '0);
    bus(1'h1, CTRL_ADDR, '1);
    bus(1'h0, CTRL_ADDR, CTRL_WMASK);
    bus(1'h0, 4'hC, '0);
    for (int s = 0; s < 8; s++)
    begin
      m = (s > 3) ? 7'h01 << (s - 4) : 7'(8'h80 >> s);
      e = {9'h000, 3'(s), 1'h1, 3'(s), 1'h1, 15'h0000};
      bus(1'h1, CTRL_ADDR, e | ($urandom & ~CTRL_WMASK));
      v = ~v;
      comp_raw <= v;
      repeat (8) @(posedge mclk);
      if (s > 0)
      begin
        tk(~m, 8);
        tk(m, 2 << s);
        bus(1'h0, CTRL_ADDR, e | 32'(!v) << 8);
        tk(m, 1 << s);
        repeat (2) @(posedge mclk);
      end
      bus(1'h0, CTRL_ADDR, e | 32'(v) << 8);
    end
    bus(1'h0, STATUS_ADDR, 32'h3);
    chk("irq", '0, 32'(irq));
    bus(1'h1, MASK_ADDR, 32'h3);
    repeat (2) @(posedge mclk);
    chk("irq", 32'h1, 32'(irq));
    bus(1'h1, STATUS_ADDR, 32'h1);
    bus(1'h0, STATUS_ADDR, 32'h2);
    bus(1'h1, STATUS_ADDR, 32'h2);
    bus(1'h0, STATUS_ADDR, '0);
    chk("irq", '0, 32'(irq));
    bus(1'h1, CTRL_ADDR, '0);
    comp_raw <= 1'h1;
    repeat (8) @(posedge mclk);
    bus(1'h0, STATUS_ADDR, '0);
    bus(1'h1, CTRL_ADDR, 32'h0010_8000);
    repeat (8) @(posedge mclk);
    bus(1'h0, CTRL_ADDR, 32'h0010_8100);
    chk("out", 32'h1, 32'(comparator_output_state));
    chk("enable", 32'h1, 32'(comp_enable));
    chk("irq", 32'h1, 32'(irq));
    bus(1'h1, MASK_ADDR, '0);
    repeat (2) @(posedge mclk);
    chk("irq", '0, 32'(irq));
    reset <= 1'h1;
    @(posedge mclk);
    reset <= 1'h0;
    bus(1'h0, CTRL_ADDR, '0);
    chk("enable", '0, 32'(comp_enable));
    results();
  end
endmodule
